// >>> rtl/ccarr_pkg.sv
// Package of the capture/compare array: register map, field layouts,
// mode encodings and reset values.
// Assumes one system clock and a single-cycle register port.
package ccarr_pkg;

   // ------------------------------------------------------------------
   // Sizes
   // ------------------------------------------------------------------
   localparam int ADDR_W  = 6;
   localparam int DATA_W  = 16;
   localparam int NUM_CH  = 16;
   localparam int NUM_PIN = 12;
   localparam int NUM_TB  = 2;
   localparam int DBL_OFS = 8;
   localparam int PRE_W   = 7;

   // ------------------------------------------------------------------
   // Register offsets (word index on the register port)
   // ------------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFS_TB_CTRL  = 6'h00;
   localparam logic [ADDR_W-1:0] OFS_TB_CNT   = 6'h01;
   localparam logic [ADDR_W-1:0] OFS_TB_RLD   = 6'h02;
   localparam logic [ADDR_W-1:0] TB_STRIDE    = 6'h03;
   localparam logic [ADDR_W-1:0] OFS_GLB_CTRL = 6'h06;
   localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 6'h07;
   localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 6'h08;
   localparam logic [ADDR_W-1:0] OFS_CH_MODE  = 6'h10;
   localparam logic [ADDR_W-1:0] OFS_CH_VAL   = 6'h20;

   // ------------------------------------------------------------------
   // Field layouts and encodings
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      SRC_PRESC = 2'h0,
      SRC_GPT   = 2'h1,
      SRC_EXT   = 2'h2
   } ccarr_src_t;

   typedef struct packed {
      logic [9:0] rsvd;
      ccarr_src_t src;
      logic [2:0] presc;
      logic       run;
   } ccarr_tbctrl_t;

   typedef enum logic [1:0] {
      CMP_IRQ_MULTI = 2'h0,
      CMP_TOGGLE    = 2'h1,
      CMP_IRQ_ONCE  = 2'h2,
      CMP_SET_CLR   = 2'h3
   } ccarr_cmode_t;

   typedef struct packed {
      logic         dbl;
      logic         single;
      logic [1:0]   edge_sel;
      ccarr_cmode_t cmode;
      logic         capture;
      logic         tb_sel;
   } ccarr_chmode_t;

   localparam int            CHMODE_W    = 8;
   localparam logic [2:0]    STAGGER_MIN = 3'h3;
   localparam logic [15:0]   CNT_TOP     = 16'hffff;
   localparam logic [15:0]   RST_WORD    = 16'h0000;
   localparam ccarr_tbctrl_t RST_TBCTRL  = '{10'h000, SRC_PRESC, 3'h0, 1'b0};
   localparam ccarr_chmode_t RST_CHMODE  = '{1'b0, 1'b0, 2'h0, CMP_IRQ_MULTI, 1'b0, 1'b0};

endpackage

// >>> rtl/ccarr_capture_compare_array.sv
// Capture/compare array: two reloadable time bases, sixteen
// capture/compare channels, twelve port pins, one interrupt line.
// Assumes pins and the external count input are asynchronous, and the
// gp timer overflow pulse comes from logic on clk_sys.
// Contract
// - Sixteen channels, one-cycle or eight-cycle staggered resolution
// - Two 16-bit time bases with reload registers
// - Time base clock: prescaled clock or gp overflow
// - Time base a also counts external input events
// - Channel picks time base and capture/compare
// - Twelve channels own a capture/output pin
// - Mode 0: interrupt per match, pin untouched
// - Mode 1: pin toggles on every match
// - Mode 2: one match interrupt per period
// - Mode 3: pin high on match, low at overflow
// - Double mode: two channels toggle one shared pin
// - Single event option disarms channel after one action
// - Capture latches assigned time base count on edge
// - Each capture raises its channel interrupt request
// - Capture edge: rising, falling or both
// - Compare channels match only in the cycle after their time base advances
`timescale 1ns/100ps
`default_nettype none

module ccarr_capture_compare_array
   import ccarr_pkg::*;
(
   input  wire logic              clk_sys,
   input  wire logic              rstn,
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic [DATA_W-1:0] reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic      [DATA_W-1:0] reg_rdata,
   input  wire logic [NUM_PIN-1:0] pin_in,
   output logic      [NUM_PIN-1:0] pin_out,
   output logic      [NUM_PIN-1:0] pin_oe_n,
   input  wire logic              ext_count_in,
   input  wire logic              gpt_ovf,
   output logic                   irq
);

   // ------------------------------------------------------------------
   // Helper functions
   // ------------------------------------------------------------------
   function automatic logic addr_hit(input logic [ADDR_W-1:0] a,
                                     input logic [ADDR_W-1:0] ofs);
      return a == ofs;
   endfunction

   function automatic logic presc_tick(input logic [2:0]       p,
                                       input logic [PRE_W-1:0] cnt);
      logic [PRE_W-1:0] mask;
      mask = (PRE_W'(1) << p) - PRE_W'(1);
      return (cnt & mask) == mask;
   endfunction

   function automatic logic edge_hit(input logic [1:0] sel,
                                     input logic       prev,
                                     input logic       cur);
      return (sel[0] & cur & ~prev) | (sel[1] & ~cur & prev);
   endfunction

   // ------------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------------
   logic [NUM_PIN-1:0] pin_s1_reg;
   logic [NUM_PIN-1:0] pin_s2_reg;
   logic [NUM_PIN-1:0] pin_s3_reg;
   logic               ext_s1_reg;
   logic               ext_s2_reg;
   logic               ext_s3_reg;

   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
      begin
         pin_s1_reg <= '0;
         pin_s2_reg <= '0;
         pin_s3_reg <= '0;
         ext_s1_reg <= 1'b0;
         ext_s2_reg <= 1'b0;
         ext_s3_reg <= 1'b0;
      end
      else
      begin
         pin_s1_reg <= pin_in;
         pin_s2_reg <= pin_s1_reg;
         pin_s3_reg <= pin_s2_reg;
         ext_s1_reg <= ext_count_in;
         ext_s2_reg <= ext_s1_reg;
         ext_s3_reg <= ext_s2_reg;
      end
   end

   wire ext_rise = ext_s2_reg & ~ext_s3_reg;

   // ------------------------------------------------------------------
   // Global control and prescaler
   // ------------------------------------------------------------------
   logic             stagger_reg;
   logic [PRE_W-1:0] presc_reg;

   wire wr_glb = reg_wr & addr_hit(reg_addr, OFS_GLB_CTRL);

   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
      begin
         stagger_reg <= 1'b0;
         presc_reg   <= '0;
      end
      else
      begin
         presc_reg <= presc_reg + PRE_W'(1);
         if (wr_glb)
            stagger_reg <= reg_wdata[0];
      end
   end

   // ------------------------------------------------------------------
   // Time bases
   // ------------------------------------------------------------------
   ccarr_tbctrl_t tb_ctrl_reg [NUM_TB];
   logic [15:0]   tb_cnt_reg  [NUM_TB];
   logic [15:0]   tb_rld_reg  [NUM_TB];
   logic [NUM_TB-1:0] tb_adv_reg;
   logic [NUM_TB-1:0] tb_ovf_reg;

   genvar b;
   generate
      for (b = 0; b < NUM_TB; b++)
      begin : g_tb
         localparam logic [ADDR_W-1:0] BASE = ADDR_W'(b) * TB_STRIDE;
         wire wr_ctrl = reg_wr & addr_hit(reg_addr, BASE + OFS_TB_CTRL);
         wire wr_cnt  = reg_wr & addr_hit(reg_addr, BASE + OFS_TB_CNT);
         wire wr_rld  = reg_wr & addr_hit(reg_addr, BASE + OFS_TB_RLD);
         wire [2:0] p_eff = (stagger_reg && tb_ctrl_reg[b].presc < STAGGER_MIN) ?
                            STAGGER_MIN : tb_ctrl_reg[b].presc;
         wire src_tick = (tb_ctrl_reg[b].src == SRC_PRESC) ? presc_tick(p_eff, presc_reg) :
                         (tb_ctrl_reg[b].src == SRC_GPT)   ? gpt_ovf :
                         (tb_ctrl_reg[b].src == SRC_EXT)   ? (b == 0) && ext_rise :
                         1'b0;
         wire tick    = tb_ctrl_reg[b].run & src_tick;
         wire ovf_now = tick & (tb_cnt_reg[b] == CNT_TOP);
         wire [15:0] cnt_next = wr_cnt  ? reg_wdata :
                                ovf_now ? tb_rld_reg[b] :
                                tick    ? tb_cnt_reg[b] + 16'h0001 :
                                tb_cnt_reg[b];

         always_ff @(posedge clk_sys)
         begin
            if (!rstn)
            begin
               tb_ctrl_reg[b] <= RST_TBCTRL;
               tb_cnt_reg[b]  <= RST_WORD;
               tb_rld_reg[b]  <= RST_WORD;
               tb_adv_reg[b]  <= 1'b0;
               tb_ovf_reg[b]  <= 1'b0;
            end
            else
            begin
               tb_cnt_reg[b] <= cnt_next;
               tb_adv_reg[b] <= tick & ~wr_cnt;
               tb_ovf_reg[b] <= ovf_now & ~wr_cnt;
               if (wr_ctrl)
                  tb_ctrl_reg[b] <= '{10'h000, ccarr_src_t'(reg_wdata[5:4]),
                                      reg_wdata[3:1], reg_wdata[0]};
               if (wr_rld)
                  tb_rld_reg[b] <= reg_wdata;
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------------
   // Capture/compare channels
   // ------------------------------------------------------------------
   ccarr_chmode_t     mode_reg  [NUM_CH];
   logic [15:0]       val_reg   [NUM_CH];
   logic [NUM_CH-1:0] armed_reg;
   logic [NUM_CH-1:0] done_reg;
   logic [NUM_CH-1:0] ch_act;
   logic [NUM_CH-1:0] ch_event;

   genvar i;
   generate
      for (i = 0; i < NUM_CH; i++)
      begin : g_ch
         wire wr_mode = reg_wr & addr_hit(reg_addr, OFS_CH_MODE + ADDR_W'(i));
         wire wr_val  = reg_wr & addr_hit(reg_addr, OFS_CH_VAL + ADDR_W'(i));
         wire sel     = mode_reg[i].tb_sel;
         wire once    = (mode_reg[i].cmode == CMP_IRQ_ONCE) ||
                        (mode_reg[i].cmode == CMP_SET_CLR);
         wire cmp_hit = ~mode_reg[i].capture & armed_reg[i] & tb_adv_reg[sel] &
                        (tb_cnt_reg[sel] == val_reg[i]);
         wire pin_edge;
         if (i < NUM_PIN)
         begin : g_pin_edge
            assign pin_edge = edge_hit(mode_reg[i].edge_sel,
                                       pin_s3_reg[i], pin_s2_reg[i]);
         end
         else
         begin : g_no_pin
            assign pin_edge = 1'b0;
         end
         wire cap_hit = mode_reg[i].capture & armed_reg[i] & pin_edge;
         wire act     = cmp_hit & ~(once & done_reg[i]);

         assign ch_act[i]   = act;
         assign ch_event[i] = act | cap_hit;

         always_ff @(posedge clk_sys)
         begin
            if (!rstn)
            begin
               mode_reg[i]  <= RST_CHMODE;
               val_reg[i]   <= RST_WORD;
               armed_reg[i] <= 1'b0;
               done_reg[i]  <= 1'b0;
            end
            else
            begin
               if (wr_mode)
                  mode_reg[i] <= ccarr_chmode_t'(reg_wdata[CHMODE_W-1:0]);
               if (cap_hit)
                  val_reg[i] <= tb_cnt_reg[sel];
               else if (wr_val)
                  val_reg[i] <= reg_wdata;
               if (wr_mode)
                  armed_reg[i] <= 1'b1;
               else if (mode_reg[i].single && (act || cap_hit))
                  armed_reg[i] <= 1'b0;
               if (act)
                  done_reg[i] <= 1'b1;
               else if (tb_ovf_reg[sel])
                  done_reg[i] <= 1'b0;
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------------
   // Pin outputs
   // ------------------------------------------------------------------
   genvar p;
   generate
      for (p = 0; p < NUM_PIN; p++)
      begin : g_pin
         wire partner_tog;
         if (p < DBL_OFS)
         begin : g_dbl
            assign partner_tog = ch_act[p+DBL_OFS] & mode_reg[p+DBL_OFS].dbl;
         end
         else
         begin : g_nodbl
            assign partner_tog = 1'b0;
         end
         wire own_tog = ch_act[p] & (mode_reg[p].cmode == CMP_TOGGLE);
         wire setclr  = ~mode_reg[p].capture & (mode_reg[p].cmode == CMP_SET_CLR);
         wire base    = (setclr && ch_act[p]) ? 1'b1 :
                        (setclr && tb_ovf_reg[mode_reg[p].tb_sel]) ? 1'b0 :
                        pin_out[p];
         wire out_next = base ^ own_tog ^ partner_tog;

         always_ff @(posedge clk_sys)
         begin
            if (!rstn)
            begin
               pin_out[p]  <= 1'b0;
               pin_oe_n[p] <= 1'b1;
            end
            else
            begin
               pin_out[p]  <= out_next;
               pin_oe_n[p] <= mode_reg[p].capture;
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------------
   // Interrupt status, mask and line
   // ------------------------------------------------------------------
   logic [NUM_CH-1:0] stat_reg;
   logic [NUM_CH-1:0] mask_reg;

   wire wr_stat = reg_wr & addr_hit(reg_addr, OFS_IRQ_STAT);
   wire wr_mask = reg_wr & addr_hit(reg_addr, OFS_IRQ_MASK);
   wire [NUM_CH-1:0] stat_clr  = wr_stat ? reg_wdata : '0;
   // New events win over a clear in the same cycle
   wire [NUM_CH-1:0] stat_next = (stat_reg & ~stat_clr) | ch_event;

   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
      begin
         stat_reg <= '0;
         mask_reg <= '0;
         irq      <= 1'b0;
      end
      else
      begin
         stat_reg <= stat_next;
         irq      <= |(stat_reg & mask_reg);
         if (wr_mask)
            mask_reg <= reg_wdata;
      end
   end

   // ------------------------------------------------------------------
   // Read port
   // ------------------------------------------------------------------
   wire [3:0] rd_idx  = reg_addr[3:0];
   wire       rd_tb   = (reg_addr >= OFS_TB_CTRL) && (reg_addr < OFS_GLB_CTRL);
   wire       rd_tbi  = reg_addr >= TB_STRIDE;
   wire [ADDR_W-1:0] rd_tbf = rd_tbi ? reg_addr - TB_STRIDE : reg_addr;
   wire [DATA_W-1:0] rd_tb_word =
      (rd_tbf == OFS_TB_CTRL) ? tb_ctrl_reg[rd_tbi] :
      (rd_tbf == OFS_TB_CNT)  ? tb_cnt_reg[rd_tbi] :
      tb_rld_reg[rd_tbi];
   wire [DATA_W-1:0] rd_mux =
      rd_tb                                   ? rd_tb_word :
      addr_hit(reg_addr, OFS_GLB_CTRL)        ? {15'h0000, stagger_reg} :
      addr_hit(reg_addr, OFS_IRQ_STAT)        ? stat_reg :
      addr_hit(reg_addr, OFS_IRQ_MASK)        ? mask_reg :
      (reg_addr[5:4] == OFS_CH_MODE[5:4])     ? {8'h00, mode_reg[rd_idx]} :
      (reg_addr[5:4] == OFS_CH_VAL[5:4])      ? val_reg[rd_idx] :
      RST_WORD;

   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
         reg_rdata <= RST_WORD;
      else
         reg_rdata <= reg_rd ? rd_mux : RST_WORD;
   end

endmodule

`default_nettype wire

// >>> tb/ccarr_cc_monitor.sv
// Port checker of the capture/compare array.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/100ps
`default_nettype none

module ccarr_cc_monitor
   import ccarr_pkg::*;
(
   input wire logic               clk_sys,
   input wire logic               rstn,
   input wire logic [ADDR_W-1:0]  reg_addr,
   input wire logic [DATA_W-1:0]  reg_wdata,
   input wire logic               reg_wr,
   input wire logic               reg_rd,
   input wire logic [DATA_W-1:0]  reg_rdata,
   input wire logic [NUM_PIN-1:0] pin_in,
   input wire logic [NUM_PIN-1:0] pin_out,
   input wire logic [NUM_PIN-1:0] pin_oe_n,
   input wire logic               ext_count_in,
   input wire logic               gpt_ovf,
   input wire logic               irq
);
   // ------------------------------------------------------------------
   // Sequences and properties
   // ------------------------------------------------------------------
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   sequence s_zero_read;
      reg_rd && (reg_addr == OFS_IRQ_STAT || reg_addr == OFS_IRQ_MASK) ##1 reg_rdata == 16'h0000;
   endsequence
   sequence s_mask_off;
      reg_wr && reg_addr == OFS_IRQ_MASK && reg_wdata == 16'h0000 ##1 !reg_wr;
   endsequence
   property p_val_rb;
      logic [5:0]  a;
      logic [15:0] d;
      (reg_wr && reg_addr[5:2] == 4'hb, a = reg_addr, d = reg_wdata) ##1 (reg_rd && reg_addr == a)
         |=> reg_rdata == d;
   endproperty
   property p_oe_follow;
      logic [3:0] ch;
      logic       cap;
      (reg_wr && reg_addr[5:4] == 2'h1 && reg_addr[3:0] < 4'hc, ch = reg_addr[3:0],
         cap = reg_wdata[1]) |-> ##2 pin_oe_n[ch] == cap;
   endproperty
   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
      else $error("read data outside read answer cycle");
   unmapped_rd_a: assert property (reg_rd && (reg_addr inside {[6'h09:6'h0f], [6'h30:6'h3f]})
      |=> reg_rdata == 16'h0000) else $error("unmapped read not zero");
   val_rb_a: assert property (p_val_rb) else $error("channel value read back wrong");
   oe_follow_a: assert property (p_oe_follow) else $error("pin enable not following mode");
   oe_cause_a: assert property ($changed(pin_oe_n) |->
      $past(reg_wr && reg_addr[5:4] == 2'h1, 1) || $past(reg_wr && reg_addr[5:4] == 2'h1, 2)
      || !$past(rstn, 2))
      else $error("pin enable changed without mode write");
   rst_state_a: assert property ($rose(rstn) |-> pin_oe_n == 12'hfff && pin_out == 12'h000
      && !irq) else $error("outputs not idle after reset");
   irq_zero_a: assert property (s_zero_read |-> !irq) else $error("irq without flag");
   mask_off_a: assert property (s_mask_off |=> !irq) else $error("irq high with mask clear");
endmodule

bind ccarr_capture_compare_array ccarr_cc_monitor u_mon (.clk_sys(clk_sys), .rstn(rstn),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
   .ext_count_in(ext_count_in), .gpt_ovf(gpt_ovf), .irq(irq));
`default_nettype wire

// >>> tb/ccarr_pin_model.sv
// Model of the port pins, the external count input and the gp timer.
// Assumes the bench calls its tasks; pins are held between calls.
`timescale 1ns/100ps
`default_nettype none

module ccarr_pin_model
(
   input  wire logic        clk_sys,
   output logic      [11:0] pin_in,
   output logic             ext_count_in,
   output logic             gpt_ovf
);
   initial
   begin
      pin_in = 12'h000;
      ext_count_in = 1'b0;
      gpt_ovf = 1'b0;
   end
   // One-cycle overflow pulses of the gp timer with idle gaps
   task automatic gpt_pulses(input int n);
      repeat (n)
      begin
         @(posedge clk_sys) gpt_ovf <= 1'b1;
         @(posedge clk_sys) gpt_ovf <= 1'b0;
         repeat (2) @(posedge clk_sys);
      end
   endtask
   // Slow external events, long enough for the input synchroniser
   task automatic ext_pulses(input int n);
      repeat (n)
      begin
         @(posedge clk_sys) ext_count_in <= 1'b1;
         repeat (4) @(posedge clk_sys);
         ext_count_in <= 1'b0;
         repeat (4) @(posedge clk_sys);
      end
   endtask
   task automatic set_pin(input int i, input logic v);
      @(posedge clk_sys) pin_in[i] <= v;
      repeat (6) @(posedge clk_sys);
   endtask
endmodule
`default_nettype wire

// >>> tb/tb.sv
// Self-checking bench of the capture/compare array.
// Assumes the pin model drives pins, count input and gp overflow.
`timescale 1ns/100ps
`default_nettype none

module tb;
   import ccarr_pkg::*;
   logic clk_sys = 1'b0;
   logic rstn;
   logic [5:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata, d;
   logic reg_wr, reg_rd, ext_count_in, gpt_ovf, irq;
   logic [11:0] pin_in, pin_out, pin_oe_n;
   int err_total = 0;
   int checks = 0;
   int cyc = 0;
   int n;
   logic [15:0] cm [6] = '{16'h0012, 16'h0012, 16'h0022, 16'h0022, 16'h0032, 16'h0032};
   logic [15:0] cc [6] = '{16'h1234, 16'h4321, 16'h4321, 16'h4321, 16'h5555, 16'h6666};
   logic [15:0] ce [6] = '{16'h1234, 16'h1234, 16'h1234, 16'h4321, 16'h5555, 16'h6666};
   logic [5:0]  ra [7] = '{6'h00, 6'h01, 6'h02, 6'h04, 6'h07, 6'h08, 6'h25};

   always #2 clk_sys = ~clk_sys;

   ccarr_capture_compare_array u_dut (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_count_in(ext_count_in),
      .gpt_ovf(gpt_ovf), .irq(irq));
   ccarr_pin_model u_pm (.clk_sys(clk_sys), .pin_in(pin_in), .ext_count_in(ext_count_in),
      .gpt_ovf(gpt_ovf));

   // ------------------------------------------------------------------
   // Register port tasks and comparison
   // ------------------------------------------------------------------
   task automatic wr(input logic [5:0] a, input logic [15:0] v);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [5:0] a, output logic [15:0] v);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      @(negedge clk_sys);
      v = reg_rdata;
   endtask
   // Write, then read the same word after one idle cycle
   task automatic wr_rd(input logic [5:0] a, input logic [15:0] v, output logic [15:0] q);
      wr(a, v);
      rd(a, q);
   endtask
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic pin_wait(input int i, output int k);
      logic v;
      v = pin_out[i];
      k = 0;
      while (pin_out[i] === v && k < 300)
      begin
         @(negedge clk_sys);
         k++;
      end
   endtask
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   always @(posedge clk_sys)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         err_total++;
         give_verdict;
      end
   end

   // ------------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------------
   initial
   begin
      rstn = 1'b0;
      reg_addr = 6'h00;
      reg_wdata = 16'h0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      repeat (20) @(posedge clk_sys);
      rstn <= 1'b1;
      foreach (ra[i])
      begin
         rd(ra[i], d);
         cmp(d, 16'h0000);
      end
      wr(6'h09, 16'hffff);
      rd(6'h09, d);
      cmp(d, 16'h0000);
      wr(OFS_TB_RLD + TB_STRIDE, 16'hffe0);
      rd(OFS_TB_RLD + TB_STRIDE, d);
      cmp(d, 16'hffe0);
      @(posedge clk_sys);
      reg_addr <= OFS_CH_VAL + 6'h0e;
      reg_wdata <= 16'ha5c3;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      @(negedge clk_sys);
      cmp(reg_rdata, 16'ha5c3);
      // Capture on channel 5 with time base a stopped at known counts
      for (int i = 0; i < 6; i++)
      begin
         wr(OFS_CH_MODE + 6'h05, cm[i]);
         wr(OFS_TB_CNT, cc[i]);
         u_pm.set_pin(5, i[0] ? 1'b0 : 1'b1);
         rd(OFS_CH_VAL + 6'h05, d);
         cmp(d, ce[i]);
      end
      rd(OFS_IRQ_STAT, d);
      cmp(d & 16'h0020, 16'h0020);
      wr(OFS_IRQ_STAT, 16'hffff);
      rd(OFS_IRQ_STAT, d);
      cmp(d, 16'h0000);
      // Compare channels on time base a, period of 32 cycles
      wr(OFS_TB_RLD, 16'hffe0);
      wr(OFS_TB_CNT, 16'hffe0);
      wr(OFS_CH_VAL + 6'h00, 16'hffe8);
      for (int c = 1; c < 5; c++)
         wr(OFS_CH_VAL + 6'(c), 16'hfff0);
      wr(OFS_CH_MODE + 6'h00, 16'h0004);
      wr(OFS_CH_MODE + 6'h01, 16'h000c);
      wr(OFS_CH_MODE + 6'h02, 16'h0000);
      wr(OFS_CH_MODE + 6'h03, 16'h0008);
      wr(OFS_CH_MODE + 6'h04, 16'h0040);
      wr(OFS_TB_CTRL, 16'h0001);
      repeat (100) @(posedge clk_sys);
      wr(OFS_IRQ_STAT, 16'hffff);
      repeat (100) @(posedge clk_sys);
      rd(OFS_IRQ_STAT, d);
      cmp(d & 16'h001f, 16'h000f);
      cmp({4'h0, pin_out & 12'h01c}, 16'h0000);
      pin_wait(0, n);
      pin_wait(0, n);
      cmp(16'(n), 16'h0020);
      if (pin_out[1] === 1'b1)
         pin_wait(1, n);
      pin_wait(1, n);
      pin_wait(1, n);
      cmp(16'(n), 16'h0010);
      wr(OFS_CH_VAL + 6'h08, 16'hfff8);
      wr(OFS_CH_MODE + 6'h08, 16'h0084);
      pin_wait(0, n);
      pin_wait(0, n);
      cmp(16'(n), 16'h0010);
      wr(OFS_IRQ_MASK, 16'h0004);
      repeat (40) @(posedge clk_sys);
      cmp({15'h0, irq}, 16'h0001);
      wr(OFS_IRQ_MASK, 16'h0000);
      repeat (2) @(posedge clk_sys);
      cmp({15'h0, irq}, 16'h0000);
      // Time base b on gp overflow, time base a on external events
      wr(OFS_TB_CNT + TB_STRIDE, 16'h0000);
      wr(OFS_TB_CTRL + TB_STRIDE, 16'h0011);
      u_pm.gpt_pulses(5);
      rd(OFS_TB_CNT + TB_STRIDE, d);
      cmp(d, 16'h0005);
      wr(OFS_TB_CTRL, 16'h0000);
      wr(OFS_TB_CNT, 16'h0000);
      wr(OFS_TB_CTRL, 16'h0021);
      u_pm.ext_pulses(3);
      rd(OFS_TB_CNT, d);
      cmp(d, 16'h0003);
      // Staggered mode: undivided prescaler forced to one tick per 8 cycles
      wr_rd(OFS_GLB_CTRL, 16'h0001, d);
      cmp(d, 16'h0001);
      wr(OFS_TB_CNT + TB_STRIDE, 16'h0000);
      wr(OFS_TB_CTRL + TB_STRIDE, 16'h0001);
      repeat (78) @(posedge clk_sys);
      wr(OFS_TB_CTRL + TB_STRIDE, 16'h0000);
      rd(OFS_TB_CNT + TB_STRIDE, d);
      cmp(d, 16'h000a);
      give_verdict;
   end
endmodule
`default_nettype wire
